// *** alarm_params.svh ***
// Function
// - every input and every enabled temperature result is checked on each conversion cycle
// - a flag sets only after N consecutive out-of-range evaluations
// - an in-range result before N keeps the flag clear and restarts counting
// - held flags stay set until the cause is gone and status is read
// - held flags clear only by read after cause clears, or by reset; bit 2 also clears while local is off
// - status read clears flags; ones still out of limit stay set
// - with hold disabled each flag follows its condition directly
// - status is read-only at 4Fh, resets 0000h, bits 15, 1, 0 read zero
// - bit 14 flags input 0 or pair 0/1, bit 12 input 2 or pair 2/3
// - bit 13 flags input 1, bit 11 flags input 3 out of range
// - bit 10 flags local under low bound, bit 9 local over high bound
// - local temperature flags only checked while local sensor enabled
// - bits 8 and 7 flag remote A under and over, when enabled
// - bits 6 and 5 flag remote B under and over, when enabled
// - bits 4 and 3 flag remote A and B sensor faults, when enabled
// - bit 2 sets at die 150 C, clears with 8 C hysteresis, zero if local off
// - enabled set flags in bits 14 to 3 pull the active-low alarm output low; bit 2 does not
// - hold disable is control bit 2, resetting to zero for latched default
`ifndef ALARM_PARAMS_SVH
`define ALARM_PARAMS_SVH

// register indices; byte address is four times the index
`define IDX_ALARM_FLAGS 8'h4F
`define IDX_ALARM_CONTROL 8'h4E
`define IDX_IRQ_STATUS 8'h60
`define IDX_IRQ_MASK 8'h61
`define IDX_SOFT_RESET 8'h7C

`define ALARM_FLAGS_RESET 16'h0000
`define ALARM_CONTROL_RESET 16'h0000
`define FLAGS_VALID_MASK 16'h7FFC
`define CONTROL_VALID_MASK 16'h7FFC

// flag bit positions
`define BIT_INPUT0 14
`define BIT_INPUT1 13
`define BIT_INPUT2 12
`define BIT_INPUT3 11
`define BIT_LOCAL_UNDER 10
`define BIT_LOCAL_OVER 9
`define BIT_REMOTE_A_UNDER 8
`define BIT_REMOTE_A_OVER 7
`define BIT_REMOTE_B_UNDER 6
`define BIT_REMOTE_B_OVER 5
`define BIT_REMOTE_A_FAULT 4
`define BIT_REMOTE_B_FAULT 3
`define BIT_DIE_OVERHEAT 2
`define BIT_HOLD_DISABLE 2
`define BIT_SOFT_RESET 0

// die temperature in whole degrees C
`define DIE_SET_C 150
`define DIE_HYST_C 8

`endif

// *** alarm_pkg.sv ***
package alarm_pkg;

    typedef logic [15:0] flag_word_t;

    typedef enum logic [2:0] {
        SEL_NONE = 3'h0,
        SEL_FLAGS = 3'h1,
        SEL_CONTROL = 3'h3,
        SEL_IRQ_STATUS = 3'h2,
        SEL_IRQ_MASK = 3'h6,
        SEL_SOFT_RESET = 3'h7
    } reg_sel_t;

endpackage

// *** alarm_status_register.sv ***
// The Avalon-MM interface to the registers was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "alarm_params.svh"

module alarm_status_register #(
    parameter int CNT_W = 4,
    parameter int TEMP_W = 10
) (
    input wire logic clk,                          // 100 MHz system clock
    input wire logic rst,                          // sync reset, high
    input wire logic [9:0] address,                // avalon byte address
    input wire logic read,                         // avalon read
    input wire logic write,                        // avalon write
    input wire logic [31:0] writedata,             // avalon write data
    input wire logic [3:0] byteenable,             // avalon byte lanes
    output logic [31:0] readdata,                  // avalon read data
    output logic waitrequest,                      // avalon stall
    input wire logic eval_strobe,                  // conversion cycle result ready
    input wire logic [3:0] input_out_of_range,     // inputs 0..3 beyond limits
    input wire logic local_under,                  // local below low bound
    input wire logic local_over,                   // local above high bound
    input wire logic remote_a_under,               // remote a below low bound
    input wire logic remote_a_over,                // remote a above high bound
    input wire logic remote_b_under,               // remote b below low bound
    input wire logic remote_b_over,                // remote b above high bound
    input wire logic remote_a_fault,               // remote a open or short
    input wire logic remote_b_fault,               // remote b open or short
    input wire logic local_sensor_enable,          // local sensor on
    input wire logic remote_a_enable,              // remote a on
    input wire logic remote_b_enable,              // remote b on
    input wire logic signed [TEMP_W-1:0] die_temp, // die temperature, degrees C
    input wire logic [CNT_W-1:0] persist_n,        // consecutive count n
    output logic alarm_n,                          // alarm output, low active
    output logic irq                               // interrupt, high level
);

    ////////////////////////////////////////////////////////////////////////////
    // registers and bus state

    alarm_pkg::flag_word_t flags;
    alarm_pkg::flag_word_t control;
    alarm_pkg::flag_word_t irq_status;
    alarm_pkg::flag_word_t irq_mask;
    alarm_pkg::flag_word_t next_flags;
    alarm_pkg::flag_word_t cond;
    alarm_pkg::flag_word_t qualified;
    alarm_pkg::flag_word_t next_control;
    logic [`BIT_INPUT0:`BIT_DIE_OVERHEAT] src_qualified;
    alarm_pkg::reg_sel_t sel;
    logic ack;
    logic req;
    logic done;
    logic rd_clear;
    logic soft_clr;
    logic hold_dis;
    logic die_hot;
    logic [15:0] wmask;

    assign hold_dis = control[`BIT_HOLD_DISABLE];
    assign wmask = {{8{byteenable[1]}}, {8{byteenable[0]}}};

    ////////////////////////////////////////////////////////////////////////////
    // avalon slave: one wait cycle on every access

    assign req = read || write;
    assign waitrequest = req && !ack;
    assign done = req && ack;

    always_ff @(posedge clk) begin
        if (rst) begin
            ack <= 1'b0;
        end else begin
            ack <= req && !ack;
        end
    end

    always_comb begin
        if (address[1:0] != 2'h0) begin
            sel = alarm_pkg::SEL_NONE;
        end else if (address[9:2] == `IDX_ALARM_FLAGS) begin
            sel = alarm_pkg::SEL_FLAGS;
        end else if (address[9:2] == `IDX_ALARM_CONTROL) begin
            sel = alarm_pkg::SEL_CONTROL;
        end else if (address[9:2] == `IDX_IRQ_STATUS) begin
            sel = alarm_pkg::SEL_IRQ_STATUS;
        end else if (address[9:2] == `IDX_IRQ_MASK) begin
            sel = alarm_pkg::SEL_IRQ_MASK;
        end else if (address[9:2] == `IDX_SOFT_RESET) begin
            sel = alarm_pkg::SEL_SOFT_RESET;
        end else begin
            sel = alarm_pkg::SEL_NONE;
        end
    end

    // data captured in the wait cycle, before the read side effect
    always_ff @(posedge clk) begin
        if (rst) begin
            readdata <= 32'h0000_0000;
        end else if (read && !ack) begin
            case (sel)
                alarm_pkg::SEL_FLAGS: readdata <= {16'h0000, flags};
                alarm_pkg::SEL_CONTROL: readdata <= {16'h0000, control};
                alarm_pkg::SEL_IRQ_STATUS: readdata <= {16'h0000, irq_status};
                alarm_pkg::SEL_IRQ_MASK: readdata <= {16'h0000, irq_mask};
                default: readdata <= 32'h0000_0000;
            endcase
        end
    end

    assign rd_clear = done && read && (sel == alarm_pkg::SEL_FLAGS);
    assign soft_clr = done && write && (sel == alarm_pkg::SEL_SOFT_RESET) && byteenable[0]
        && writedata[`BIT_SOFT_RESET];

    ////////////////////////////////////////////////////////////////////////////
    // control register

    always_comb begin
        if (soft_clr) begin
            next_control = `ALARM_CONTROL_RESET;
        end else if (done && write && sel == alarm_pkg::SEL_CONTROL) begin
            next_control = (control & ~wmask) | (writedata[15:0] & wmask & `CONTROL_VALID_MASK);
        end else begin
            next_control = control;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            control <= `ALARM_CONTROL_RESET;
        end else begin
            control <= next_control;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // source conditions

    // all sources checked at each strobe
    always_comb begin
        cond = '0;
        // inputs 0 and 2, single or pair
        cond[`BIT_INPUT0] = input_out_of_range[0];
        cond[`BIT_INPUT2] = input_out_of_range[2];
        cond[`BIT_INPUT1] = input_out_of_range[1];
        cond[`BIT_INPUT3] = input_out_of_range[3];
        cond[`BIT_LOCAL_UNDER] = local_under && local_sensor_enable;
        cond[`BIT_LOCAL_OVER] = local_over && local_sensor_enable;
        cond[`BIT_REMOTE_A_UNDER] = remote_a_under && remote_a_enable;
        cond[`BIT_REMOTE_A_OVER] = remote_a_over && remote_a_enable;
        cond[`BIT_REMOTE_B_UNDER] = remote_b_under && remote_b_enable;
        cond[`BIT_REMOTE_B_OVER] = remote_b_over && remote_b_enable;
        cond[`BIT_REMOTE_A_FAULT] = remote_a_fault && remote_a_enable;
        cond[`BIT_REMOTE_B_FAULT] = remote_b_fault && remote_b_enable;
        // die overheat only with local on
        cond[`BIT_DIE_OVERHEAT] = die_hot && local_sensor_enable;
    end

    die_overheat_detect #(
        .TEMP_W(TEMP_W)
    ) u_die (
        .clk(clk),
        .rst(rst),
        .eval(eval_strobe),
        .enable(local_sensor_enable),
        .temp(die_temp),
        .hot(die_hot)
    );

    assign qualified = {1'b0, src_qualified, 2'b00};

    genvar g;
    generate
        for (g = `BIT_DIE_OVERHEAT; g <= `BIT_INPUT0; g++) begin : g_src
            persistence_counter #(
                .CNT_W(CNT_W)
            ) u_cnt (
                .clk(clk),
                .rst(rst),
                .clear(soft_clr),
                .eval(eval_strobe),
                .cond(cond[g]),
                .n(persist_n),
                .qualified(src_qualified[g])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // status flags

    always_comb begin
        if (hold_dis) begin
            next_flags = qualified;
        end else if (rd_clear) begin
            next_flags = qualified | (flags & qualified);
        end else begin
            next_flags = qualified | flags;
        end
        if (!local_sensor_enable) begin
            next_flags[`BIT_DIE_OVERHEAT] = 1'b0;
        end
        next_flags = next_flags & `FLAGS_VALID_MASK;
    end

    always_ff @(posedge clk) begin
        if (rst || soft_clr) begin
            flags <= `ALARM_FLAGS_RESET;
        end else begin
            flags <= next_flags;
        end
    end

    // enabled flags drive the alarm low
    always_ff @(posedge clk) begin
        if (rst) begin
            alarm_n <= 1'b1;
        end else begin
            alarm_n <= !(|(next_flags[`BIT_INPUT0:`BIT_REMOTE_B_FAULT]
                & next_control[`BIT_INPUT0:`BIT_REMOTE_B_FAULT]));
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // interrupt: flag rise is sticky, write one to clear

    always_ff @(posedge clk) begin
        if (rst || soft_clr) begin
            irq_status <= 16'h0000;
        end else if (done && write && sel == alarm_pkg::SEL_IRQ_STATUS) begin
            irq_status <= (irq_status & ~(writedata[15:0] & wmask)) | (next_flags & ~flags);
        end else begin
            irq_status <= irq_status | (next_flags & ~flags);
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            irq_mask <= 16'h0000;
        end else if (done && write && sel == alarm_pkg::SEL_IRQ_MASK) begin
            irq_mask <= (irq_mask & ~wmask) | (writedata[15:0] & wmask & `FLAGS_VALID_MASK);
        end
    end

    assign irq = |(irq_status & irq_mask);

    ////////////////////////////////////////////////////////////////////////////
    // checks

    chk_reserved_zero: assert property (@(posedge clk) disable iff (rst)
        (flags[15] || flags[1] || flags[0]) == 1'b0)
        else $error("reserved status bit set");

    chk_unlatched_follow: assert property (@(posedge clk) disable iff (rst)
        (hold_dis && !soft_clr) |=> flags[14:3] == $past(qualified[14:3]))
        else $error("unheld flag does not follow its condition");

    chk_latched_hold: assert property (@(posedge clk) disable iff (rst)
        (!hold_dis && !soft_clr && !rd_clear) |=> (flags[14:3] & $past(flags[14:3])) == $past(flags[14:3]))
        else $error("held flag dropped without read");

    chk_read_clear: assert property (@(posedge clk) disable iff (rst)
        (!hold_dis && rd_clear && !soft_clr) |=> flags[14:3] == $past(qualified[14:3]))
        else $error("status read did not clear resolved flags");

    chk_local_ignored: assert property (@(posedge clk) disable iff (rst)
        (!local_sensor_enable && eval_strobe) |=> qualified[10:9] == 2'b00)
        else $error("local flag source counted while disabled");

    chk_die_disabled: assert property (@(posedge clk) disable iff (rst)
        !local_sensor_enable |=> !flags[`BIT_DIE_OVERHEAT])
        else $error("overheat flag set with local sensor off");

    chk_alarm_output: assert property (@(posedge clk) disable iff (rst)
        (|(flags[14:3] & control[14:3])) |-> !alarm_n)
        else $error("enabled flag set but alarm output high");

    chk_latch_default: assert property (@(posedge clk)
        $past(rst) |-> !hold_dis)
        else $error("hold disable not zero after reset");

    chk_wait_one: assert property (@(posedge clk) disable iff (rst)
        waitrequest |=> !waitrequest)
        else $error("access stalled more than one cycle");

endmodule

`default_nettype wire

// *** alarm_status_register_tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none

module alarm_status_register_tb_top;

    typedef struct {
        logic [15:0] cw;
        logic signed [9:0] temp;
        logic [15:0] exp;
    } row_t;

    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [9:0] address = 10'h000;
    logic read = 1'b0;
    logic write = 1'b0;
    logic [31:0] writedata = 32'h0;
    logic [3:0] byteenable = 4'hF;
    logic [31:0] readdata;
    logic waitrequest;
    logic eval_strobe = 1'b0;
    logic [15:0] cw = 16'h0000;
    logic local_sensor_enable = 1'b1;
    logic remote_a_enable = 1'b1;
    logic remote_b_enable = 1'b1;
    logic signed [9:0] die_temp = 10'sh019;
    logic [3:0] persist_n = 4'h2;
    logic alarm_n;
    logic irq;
    logic irq_a;
    logic [31:0] q;
    int errors = 0;
    int checked = 0;
    row_t rows [0:13];

    always #5 clk = ~clk;

    alarm_status_register dut (
        .clk(clk),
        .rst(rst),
        .address(address),
        .read(read),
        .write(write),
        .writedata(writedata),
        .byteenable(byteenable),
        .readdata(readdata),
        .waitrequest(waitrequest),
        .eval_strobe(eval_strobe),
        .input_out_of_range({cw[11], cw[12], cw[13], cw[14]}),
        .local_under(cw[10]),
        .local_over(cw[9]),
        .remote_a_under(cw[8]),
        .remote_a_over(cw[7]),
        .remote_b_under(cw[6]),
        .remote_b_over(cw[5]),
        .remote_a_fault(cw[4]),
        .remote_b_fault(cw[3]),
        .local_sensor_enable(local_sensor_enable),
        .remote_a_enable(remote_a_enable),
        .remote_b_enable(remote_b_enable),
        .die_temp(die_temp),
        .persist_n(persist_n),
        .alarm_n(alarm_n),
        .irq(irq)
    );

    ////////////////////////////////////////////////////////////////////////////
    task automatic test_done();
        $display("comparisons %0d mismatches %0d", checked, errors);
        if (errors == 0 && checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            errors++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // one avalon transfer, held until waitrequest is seen low
    task automatic bus(input logic [9:0] a, input logic wr, input logic [15:0] d, output logic [31:0] r);
        int i;
        @(posedge clk);
        address <= a;
        read <= ~wr;
        write <= wr;
        writedata <= {16'h0000, d};
        for (i = 0; i < 20; i++) begin
            @(posedge clk);
            if (waitrequest === 1'b0) break;
        end
        if (i == 20) begin
            errors++;
            test_done();
        end
        r = readdata;
        read <= 1'b0;
        write <= 1'b0;
    endtask

    task automatic wr(input logic [9:0] a, input logic [15:0] d);
        logic [31:0] r;
        bus(a, 1'b1, d, r);
    endtask

    task automatic rd_chk(input string name, input logic [9:0] a, input logic [15:0] exp);
        logic [31:0] r;
        bus(a, 1'b0, 16'h0000, r);
        check(name, r, {16'h0000, exp});
    endtask

    // n back-to-back conversion results, then let flags settle
    task automatic pulse(input int n);
        repeat (n) begin
            @(posedge clk);
            eval_strobe <= 1'b1;
        end
        @(posedge clk);
        eval_strobe <= 1'b0;
        repeat (3) @(posedge clk);
    endtask

    task automatic apply(input logic [15:0] c, input logic signed [9:0] t, input int n);
        @(posedge clk);
        cw <= c;
        die_temp <= t;
        pulse(n);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        rows = '{'{16'h4000, 10'sh019, 16'h4000}, '{16'h2000, 10'sh019, 16'h2000},
                 '{16'h1000, 10'sh019, 16'h1000}, '{16'h0800, 10'sh019, 16'h0800},
                 '{16'h0400, 10'sh019, 16'h0400}, '{16'h0200, 10'sh019, 16'h0200},
                 '{16'h0100, 10'sh019, 16'h0100}, '{16'h0080, 10'sh019, 16'h0080},
                 '{16'h0040, 10'sh019, 16'h0040}, '{16'h0020, 10'sh019, 16'h0020},
                 '{16'h0010, 10'sh019, 16'h0010}, '{16'h0008, 10'sh019, 16'h0008},
                 '{16'h0000, 10'sh096, 16'h0004}, '{16'h7FF8, 10'sh096, 16'h7FFC}};
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        check("alarm_n_reset", {31'h0, alarm_n}, 32'h1);
        check("irq_reset", {31'h0, irq}, 32'h0);
        rd_chk("flags_reset", 10'h13C, 16'h0000);
        rd_chk("control_reset", 10'h138, 16'h0000);
        rd_chk("irq_status_reset", 10'h180, 16'h0000);
        wr(10'h138, 16'hFFFF);
        rd_chk("control_reserved", 10'h138, 16'h7FFC);
        wr(10'h13C, 16'hFFFF);
        rd_chk("flags_write", 10'h13C, 16'h0000);
        rd_chk("unmapped", 10'h200, 16'h0000);
        rd_chk("misaligned", 10'h13D, 16'h0000);
        wr(10'h138, 16'h7FF8);
        for (int k = 0; k < 14; k++) begin
            apply(rows[k].cw, rows[k].temp, 3);
            check("alarm_n_row", {31'h0, alarm_n}, {31'h0, (rows[k].exp & 16'h7FF8) == 16'h0});
            check("irq_row", {31'h0, irq}, 32'h0);
            // overheat lags one strobe, so two in-range strobes settle it
            apply(16'h0000, 10'sh019, 2);
            rd_chk("flags_row", 10'h13C, rows[k].exp);
            rd_chk("flags_row_cleared", 10'h13C, 16'h0000);
            rd_chk("irq_status_row", 10'h180, rows[k].exp);
            wr(10'h180, rows[k].exp);
            rd_chk("irq_status_w1c", 10'h180, 16'h0000);
        end
        // persistence with n = 3
        persist_n <= 4'h3;
        apply(16'h0800, 10'sh019, 2);
        apply(16'h0000, 10'sh019, 1);
        apply(16'h0800, 10'sh019, 2);
        rd_chk("flags_restart", 10'h13C, 16'h0000);
        pulse(1);
        rd_chk("flags_nth", 10'h13C, 16'h0800);
        apply(16'h0000, 10'sh019, 1);
        rd_chk("flags_nth_read", 10'h13C, 16'h0800);
        rd_chk("flags_nth_clear", 10'h13C, 16'h0000);
        persist_n <= 4'h2;
        // latched with cause still present, alarm enables off
        wr(10'h138, 16'h0000);
        apply(16'h1000, 10'sh019, 2);
        check("alarm_n_masked", {31'h0, alarm_n}, 32'h1);
        rd_chk("flags_cause", 10'h13C, 16'h1000);
        pulse(1);
        rd_chk("flags_reassert", 10'h13C, 16'h1000);
        wr(10'h138, 16'h1000);
        @(posedge clk);
        check("alarm_n_enable", {31'h0, alarm_n}, 32'h0);
        wr(10'h184, 16'h0000);
        irq_a = irq;
        wr(10'h184, 16'h7FFC);
        rd_chk("mask_readback", 10'h184, 16'h7FFC);
        check("irq_mask", {30'h0, irq_a, irq}, 32'h1);
        @(posedge clk);
        cw <= 16'h0000;
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        rd_chk("flags_hw_reset", 10'h13C, 16'h0000);
        rd_chk("irq_status_hw_reset", 10'h180, 16'h0000);
        // hold disabled: flag follows condition
        wr(10'h138, 16'h7FFC);
        apply(16'h2000, 10'sh019, 2);
        check("alarm_n_follow", {31'h0, alarm_n}, 32'h0);
        apply(16'h0000, 10'sh019, 1);
        check("alarm_n_drop", {31'h0, alarm_n}, 32'h1);
        rd_chk("flags_follow", 10'h13C, 16'h0000);
        // disabled sensors ignored
        local_sensor_enable <= 1'b0;
        remote_a_enable <= 1'b0;
        remote_b_enable <= 1'b0;
        apply(16'h07F8, 10'sh0A0, 3);
        rd_chk("flags_disabled", 10'h13C, 16'h0000);
        local_sensor_enable <= 1'b1;
        remote_a_enable <= 1'b1;
        remote_b_enable <= 1'b1;
        apply(16'h0060, 10'sh019, 3);
        rd_chk("flags_remote_b", 10'h13C, 16'h0060);
        // die overheat hysteresis
        apply(16'h0000, 10'sh095, 3);
        rd_chk("die_149", 10'h13C, 16'h0000);
        apply(16'h0000, 10'sh096, 3);
        rd_chk("die_150", 10'h13C, 16'h0004);
        apply(16'h0000, 10'sh08E, 3);
        rd_chk("die_142", 10'h13C, 16'h0004);
        apply(16'h0000, 10'sh08D, 3);
        rd_chk("die_141", 10'h13C, 16'h0000);
        // software reset
        apply(16'h4000, 10'sh019, 3);
        @(posedge clk);
        cw <= 16'h0000;
        wr(10'h1F0, 16'h0001);
        rd_chk("flags_soft_reset", 10'h13C, 16'h0000);
        rd_chk("control_soft_reset", 10'h138, 16'h0000);
        test_done();
    end

endmodule

`default_nettype wire

// *** die_overheat_detect.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "alarm_params.svh"

module die_overheat_detect #(
    parameter int TEMP_W = 10
) (
    input wire logic clk,                        // system clock
    input wire logic rst,                        // sync reset, high
    input wire logic eval,                       // one evaluation done
    input wire logic enable,                     // local sensor on
    input wire logic signed [TEMP_W-1:0] temp,   // die temperature, degrees C
    output logic hot                             // overheat with hysteresis
);

    localparam logic signed [TEMP_W-1:0] SET_LEVEL = TEMP_W'(`DIE_SET_C);
    localparam logic signed [TEMP_W-1:0] CLR_LEVEL = TEMP_W'(`DIE_SET_C - `DIE_HYST_C);

    // set at threshold, clear below hysteresis
    always_ff @(posedge clk) begin
        if (rst) begin
            hot <= 1'b0;
        end else if (!enable) begin
            hot <= 1'b0;
        end else if (eval) begin
            if (temp >= SET_LEVEL) begin
                hot <= 1'b1;
            end else if (temp < CLR_LEVEL) begin
                hot <= 1'b0;
            end
        end
    end

    chk_hyst_hold: assert property (@(posedge clk) disable iff (rst)
        (hot && eval && enable && temp >= CLR_LEVEL) |=> hot)
        else $error("overheat dropped inside hysteresis band");

endmodule

`default_nettype wire

// *** persistence_counter.sv ***
`timescale 1ns/1ps
`default_nettype none

module persistence_counter #(
    parameter int CNT_W = 4
) (
    input wire logic clk,              // system clock
    input wire logic rst,              // sync reset, high
    input wire logic clear,            // soft reset pulse
    input wire logic eval,             // one evaluation done
    input wire logic cond,             // source out of range
    input wire logic [CNT_W-1:0] n,    // consecutive count needed
    output logic qualified             // out of range n times in a row
);

    logic [CNT_W-1:0] count;
    logic [CNT_W-1:0] n_eff;

    // zero is taken as one
    assign n_eff = (n == '0) ? CNT_W'(1) : n;

    always_ff @(posedge clk) begin
        if (rst || clear) begin
            count <= '0;
            qualified <= 1'b0;
        end else if (eval) begin
            if (!cond) begin
                count <= '0;
                qualified <= 1'b0;
            end else if (count < n_eff) begin
                count <= count + CNT_W'(1);
                qualified <= (count + CNT_W'(1)) >= n_eff;
            end
        end
    end

    chk_count_restart: assert property (@(posedge clk) disable iff (rst)
        (eval && !cond) |=> (!qualified && count == '0))
        else $error("count not restarted on in-range result");

    chk_qualify_at_n: assert property (@(posedge clk) disable iff (rst)
        (eval && cond && !clear && count == n_eff - CNT_W'(1)) |=> qualified)
        else $error("source not qualified at count n");

endmodule

`default_nettype wire
